// ---- rtl/ctx_pkg.sv ----
// constants for the context switching register bank
package ctx_pkg;
  // --------------------------------------------------------------------
  // register bus geometry
  // --------------------------------------------------------------------
  localparam int unsigned ADDR_W       = 10;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned NUM_SET      = 26;
  localparam int unsigned SET_IDX_W    = 5;
  localparam int unsigned CTX_MEM_DEPTH = 256;
  localparam int unsigned CTX_MEM_AW   = 8;
  // --------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 10'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 10'h001;
  localparam logic [ADDR_W-1:0] OFS_FRAME    = 10'h002;
  localparam logic [ADDR_W-1:0] OFS_SET_A    = 10'h040;
  localparam logic [ADDR_W-1:0] OFS_SET_B    = 10'h060;
  localparam logic [ADDR_W-1:0] OFS_CTX_MEM  = 10'h100;
  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int unsigned CTRL_SEL_BIT   = 0;
  localparam int unsigned CTRL_SLAVE_BIT = 1;
  localparam int unsigned ST_EXP_BIT     = 0;
  localparam int unsigned ST_OTH_BIT     = 1;
  localparam int unsigned ST_PEND_BIT    = 2;
  localparam int unsigned EXP_ROWS_IDX   = 0;
  localparam int unsigned EXP2_ROWS_IDX  = 7;
  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic [DATA_W-1:0] SET_RST_VAL = 16'h0000;
  localparam logic [DATA_W-1:0] MEM_RST_VAL = 16'h0000;
  localparam logic [1:0]        CTRL_RST    = 2'h0;
  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam logic [1:0] STAGE_EXP = 2'h1;
  localparam logic [1:0] STAGE_ALL = 2'h2;
endpackage : ctx_pkg

// ---- rtl/ctx_frame_if.sv ----
// interface carrying frame start events and the select pipeline
`timescale 1ns/1ps
interface ctx_frame_if;
  logic frame_start;
  logic sel_req;
  logic sel_exp;
  logic sel_oth;
  logic pend;
  modport ctrl (input frame_start, input sel_req,
                output sel_exp, output sel_oth, output pend);
  modport top  (output frame_start, output sel_req,
                input sel_exp, input sel_oth, input pend);
endinterface : ctx_frame_if

// ---- rtl/ctx_stage.sv ----
// staged context select: exposure one frame, rest two frames later
`timescale 1ns/1ps
module ctx_stage
  import ctx_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   reset_n_in,
  ctx_frame_if.ctrl   frm
);
  typedef struct packed {
    logic       exp;
    logic       oth;
    logic       mid;
  } stage_t;
  stage_t st_ff;
  stage_t nxt_st;
  // ------------------------------------------------------------------
  // frame boundary pipeline
  // ------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (frm.frame_start) begin
      nxt_st.exp = frm.sel_req;
      nxt_st.mid = frm.sel_req;
      nxt_st.oth = st_ff.mid;
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign frm.sel_exp = st_ff.exp;
  assign frm.sel_oth = st_ff.oth;
  assign frm.pend    = (st_ff.oth != frm.sel_req);
  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_exp_follows: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    frm.frame_start |=> st_ff.exp == $past(frm.sel_req))
    else $error("exposure select not taken at frame start");
  a_oth_lags: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    frm.frame_start |=> st_ff.oth == $past(st_ff.mid))
    else $error("other settings did not lag by one frame");
  a_hold_mid: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    !frm.frame_start |=> $stable(st_ff))
    else $error("select stage moved between frames");
  c_switch: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(st_ff.oth));
endmodule // ctx_stage

// ---- rtl/ctx_regs.sv ----
// register bank with two switchable sets, context memory and trigger
`timescale 1ns/1ps
module ctx_regs
  import ctx_pkg::*;
#(
  parameter int unsigned NSET = NUM_SET
) (
  input  wire logic                    clk_in,
  input  wire logic                    reset_n_in,
  input  wire logic [ADDR_W-1:0]       addr_in,
  input  wire logic [DATA_W-1:0]       wdata_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  input  wire logic                    trigger_in,
  input  wire logic                    internal_start_in,
  output logic      [DATA_W-1:0]       rdata_out,
  output logic                         frame_start_out,
  output logic      [NSET*DATA_W-1:0]  active_set_out
);
  typedef struct packed {
    logic [NSET-1:0][DATA_W-1:0]          set_a;
    logic [NSET-1:0][DATA_W-1:0]          set_b;
    logic [CTX_MEM_DEPTH-1:0][DATA_W-1:0] mem;
    logic [1:0]                           ctrl;
    logic [DATA_W-1:0]                    rdata;
    logic [DATA_W-1:0]                    frames;
    logic                                 trg_s1;
    logic                                 trg_s2;
    logic                                 trg_s3;
    logic                                 fstart;
    logic [NSET-1:0][DATA_W-1:0]          act;
  } regs_t;
  regs_t r_ff;
  regs_t nxt_r;
  ctx_frame_if frm ();
  ctx_stage u_stage (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .frm        (frm)
  );
  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base,
                                    input int unsigned       n);
    in_range = (a >= base) && ({22'h0, a} < {22'h0, base} + n);
  endfunction
  // ------------------------------------------------------------------
  // frame start source
  // ------------------------------------------------------------------
  logic slave_mode;
  logic trig_rise;
  logic fstart_c;
  assign slave_mode = r_ff.ctrl[CTRL_SLAVE_BIT];
  assign trig_rise  = r_ff.trg_s2 & ~r_ff.trg_s3;
  assign fstart_c   = slave_mode ? trig_rise : internal_start_in;
  assign frm.frame_start = fstart_c;
  assign frm.sel_req     = r_ff.ctrl[CTRL_SEL_BIT];
  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [ADDR_W-1:0] off;
    off   = '0;
    nxt_r = r_ff;
    nxt_r.trg_s1 = trigger_in;
    nxt_r.trg_s2 = r_ff.trg_s1;
    nxt_r.trg_s3 = r_ff.trg_s2;
    nxt_r.fstart = fstart_c;
    if (fstart_c) begin
      nxt_r.frames = r_ff.frames + 16'h0001;
    end
    if (wr_in) begin
      if (addr_in == OFS_CTRL) begin
        nxt_r.ctrl = wdata_in[1:0];
      end else if (in_range(addr_in, OFS_SET_A, NSET)) begin
        off = addr_in - OFS_SET_A;
        nxt_r.set_a[off[SET_IDX_W-1:0]] = wdata_in;
      end else if (in_range(addr_in, OFS_SET_B, NSET)) begin
        off = addr_in - OFS_SET_B;
        nxt_r.set_b[off[SET_IDX_W-1:0]] = wdata_in;
      end else if (in_range(addr_in, OFS_CTX_MEM, CTX_MEM_DEPTH)) begin
        off = addr_in - OFS_CTX_MEM;
        nxt_r.mem[off[CTX_MEM_AW-1:0]] = wdata_in;
      end
    end
    nxt_r.rdata = '0;
    if (rd_in) begin
      if (addr_in == OFS_CTRL) begin
        nxt_r.rdata = {14'h0, r_ff.ctrl};
      end else if (addr_in == OFS_STATUS) begin
        nxt_r.rdata = {13'h0, frm.pend, frm.sel_oth, frm.sel_exp};
      end else if (addr_in == OFS_FRAME) begin
        nxt_r.rdata = r_ff.frames;
      end else if (in_range(addr_in, OFS_SET_A, NSET)) begin
        off = addr_in - OFS_SET_A;
        nxt_r.rdata = r_ff.set_a[off[SET_IDX_W-1:0]];
      end else if (in_range(addr_in, OFS_SET_B, NSET)) begin
        off = addr_in - OFS_SET_B;
        nxt_r.rdata = r_ff.set_b[off[SET_IDX_W-1:0]];
      end else if (in_range(addr_in, OFS_CTX_MEM, CTX_MEM_DEPTH)) begin
        off = addr_in - OFS_CTX_MEM;
        nxt_r.rdata = r_ff.mem[off[CTX_MEM_AW-1:0]];
      end
    end
    // active settings: exposure rows use early stage, rest the late one
    for (int i = 0; i < NSET; i++) begin
      if (i == EXP_ROWS_IDX || i == EXP2_ROWS_IDX) begin
        nxt_r.act[i] = frm.sel_exp ? r_ff.set_b[i] : r_ff.set_a[i];
      end else begin
        nxt_r.act[i] = frm.sel_oth ? r_ff.set_b[i] : r_ff.set_a[i];
      end
    end
  end
  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_ff.set_a  <= {NSET{SET_RST_VAL}};
      r_ff.set_b  <= {NSET{SET_RST_VAL}};
      r_ff.mem    <= {CTX_MEM_DEPTH{MEM_RST_VAL}};
      r_ff.ctrl   <= CTRL_RST;
      r_ff.rdata  <= '0;
      r_ff.frames <= '0;
      r_ff.trg_s1 <= 1'b0;
      r_ff.trg_s2 <= 1'b0;
      r_ff.trg_s3 <= 1'b0;
      r_ff.fstart <= 1'b0;
      r_ff.act    <= {NSET{SET_RST_VAL}};
    end else begin
      r_ff <= nxt_r;
    end
  end
  assign rdata_out       = r_ff.rdata;
  assign frame_start_out = r_ff.fstart;
  assign active_set_out  = r_ff.act;
  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_sel_a_used: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (!frm.sel_oth && !frm.sel_exp) |=> r_ff.act == $past(r_ff.set_a))
    else $error("set A not used while A selected");
  a_exp_b_next: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (fstart_c && frm.sel_req) |=> ##1
      r_ff.act[EXP_ROWS_IDX] == $past(r_ff.set_b[EXP_ROWS_IDX]))
    else $error("exposure rows did not switch after one frame");
  a_exp2_b_next: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (fstart_c && frm.sel_req) |=> ##1
      r_ff.act[EXP2_ROWS_IDX] == $past(r_ff.set_b[EXP2_ROWS_IDX]))
    else $error("second exposure rows did not switch after one frame");
  a_oth_b_late: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    frm.sel_oth |=> r_ff.act[NSET-1] == $past(r_ff.set_b[NSET-1]))
    else $error("late setting not taken from set B");
  a_exp_a_back: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (fstart_c && !frm.sel_req) |=> ##1
      r_ff.act[EXP_ROWS_IDX] == $past(r_ff.set_a[EXP_ROWS_IDX]))
    else $error("exposure rows did not return to set A");
  a_sel_read: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (rd_in && addr_in == OFS_CTRL) |=> rdata_out[1:0] == $past(r_ff.ctrl))
    else $error("select readback differs from written value");
  a_ctrl_write: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (wr_in && addr_in == OFS_CTRL) |=>
      r_ff.ctrl == $past(wdata_in[1:0]))
    else $error("select write not stored");
  a_slave_trig: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (slave_mode && $rose(r_ff.trg_s2)) |=> frame_start_out)
    else $error("trigger did not start a frame");
  a_start_refused: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (slave_mode && !trig_rise) |=> !frame_start_out)
    else $error("frame started in slave mode without trigger");
  a_trig_sync: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    ($rose(trigger_in) && slave_mode) ##1 slave_mode [*2] |=>
      frame_start_out)
    else $error("synchronised trigger edge lost");
  a_mem_wr: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (wr_in && addr_in == OFS_CTX_MEM) |=>
      r_ff.mem[0] == $past(wdata_in))
    else $error("context memory word not written");
  a_set_a_wr: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (wr_in && addr_in == OFS_SET_A) |=>
      r_ff.set_a[0] == $past(wdata_in))
    else $error("set A word not written");
  a_set_b_wr: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (wr_in && addr_in == OFS_SET_B) |=>
      r_ff.set_b[0] == $past(wdata_in))
    else $error("set B word not written");
  c_slave_frame: cover property (
    @(posedge clk_in) disable iff (!reset_n_in)
    slave_mode && fstart_c);
  c_exp_only: cover property (
    @(posedge clk_in) disable iff (!reset_n_in)
    frm.sel_exp && !frm.sel_oth);
  c_sel_b: cover property (
    @(posedge clk_in) disable iff (!reset_n_in)
    frm.sel_oth && frm.sel_exp);
  c_back_to_a: cover property (
    @(posedge clk_in) disable iff (!reset_n_in)
    $fell(frm.sel_oth));
endmodule // ctx_regs

// ---- verification/ctx_trig_model.sv ----
// external trigger controller that starts slave-mode frames
`timescale 1ns/1ps
module ctx_trig_model (
  input  wire logic clk_in,
  output logic      trigger_out
);
  initial trigger_out = 1'b0;
  // --------------------------------------------------------------------
  // trigger pulse, high two cycles, then low
  // --------------------------------------------------------------------
  task automatic pulse();
    @(posedge clk_in);
    trigger_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    trigger_out <= 1'b0;
  endtask
endmodule // ctx_trig_model

// ---- verification/tb.sv ----
// self-checking testbench for the context switching register bank
`timescale 1ns/1ps
module tb;
  import ctx_pkg::*;
  logic                      clk_in;
  logic                      reset_n_in;
  logic [ADDR_W-1:0]         addr_in;
  logic [DATA_W-1:0]         wdata_in;
  logic                      wr_in;
  logic                      rd_in;
  logic                      trigger_in;
  logic                      internal_start_in;
  logic [DATA_W-1:0]         rdata_out;
  logic                      frame_start_out;
  logic [NUM_SET*DATA_W-1:0] active_set_out;
  int                        err_total;
  int                        total_checks;
  int                        cyc;
  ctx_regs #(.NSET(NUM_SET)) u_ctx_regs (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .trigger_in(trigger_in), .internal_start_in(internal_start_in),
    .rdata_out(rdata_out), .frame_start_out(frame_start_out),
    .active_set_out(active_set_out));
  ctx_trig_model u_ctx_trig_model (.clk_in(clk_in), .trigger_out(trigger_in));
  // --------------------------------------------------------------------
  // clock, timeout and shared tasks
  // --------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [DATA_W-1:0] e,
                     input logic [DATA_W-1:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                    input string nm);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(nm, e, rdata_out);
  endtask
  task automatic frm(input logic e);
    logic seen;
    #1 seen = frame_start_out;
    repeat (8) begin
      @(posedge clk_in);
      #1 seen = seen | frame_start_out;
    end
    chk("frame_start", {15'h0, e}, {15'h0, seen});
  endtask
  task automatic start(input logic e);
    @(posedge clk_in);
    internal_start_in <= 1'b1;
    @(posedge clk_in);
    internal_start_in <= 1'b0;
    frm(e);
  endtask
  task automatic act(input logic bexp, input logic both);
    logic [DATA_W-1:0] e;
    for (int i = 0; i < NUM_SET; i++) begin
      e = (i == EXP_ROWS_IDX || i == EXP2_ROWS_IDX) ?
          {3'h0, bexp, 12'h000} : {3'h0, both, 12'h000};
      chk("active_set", e | 16'ha000 | i[15:0], active_set_out[i*16 +: 16]);
    end
  endtask
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    rd(OFS_CTRL, 16'h0000, "ctrl");
    rd(OFS_SET_B, 16'h0000, "set_b");
    chk("active_zero", 16'h0000, (|active_set_out) ? 16'h1 : 16'h0);
    $display("test reset done");
  endtask
  task automatic t_regs();
    for (int i = 0; i < NUM_SET; i++) begin
      wr(OFS_SET_A + i[ADDR_W-1:0], 16'ha000 | i[15:0]);
      wr(OFS_SET_B + i[ADDR_W-1:0], 16'hb000 | i[15:0]);
    end
    rd(OFS_SET_A + 10'h019, 16'ha019, "set_a_last");
    rd(OFS_SET_B, 16'hb000, "set_b_first");
    wr(10'h3ff, 16'h5a5a);
    rd(10'h3ff, 16'h0000, "unmapped");
    wr(OFS_CTX_MEM, 16'h1234);
    wr(OFS_CTX_MEM + 10'h0ff, 16'hbeef);
    rd(OFS_CTX_MEM, 16'h1234, "mem_first");
    rd(OFS_CTX_MEM + 10'h0ff, 16'hbeef, "mem_last");
    $display("test registers done");
  endtask
  task automatic t_switch();
    start(1'b1);
    act(1'b0, 1'b0);
    wr(OFS_CTRL, 16'h0001);
    rd(OFS_CTRL, 16'h0001, "ctrl_sel");
    rd(OFS_STATUS, 16'h0004, "status_pend");
    act(1'b0, 1'b0);
    start(1'b1);
    act(1'b1, 1'b0);
    rd(OFS_STATUS, 16'h0005, "status_exp");
    start(1'b1);
    act(1'b1, 1'b1);
    rd(OFS_STATUS, 16'h0003, "status_all");
    rd(OFS_FRAME, 16'h0003, "frame_count");
    wr(OFS_CTRL, 16'h0000);
    start(1'b1);
    act(1'b0, 1'b1);
    start(1'b1);
    act(1'b0, 1'b0);
    $display("test switch done");
  endtask
  task automatic t_slave();
    wr(OFS_CTRL, 16'h0003);
    start(1'b0);
    act(1'b0, 1'b0);
    fork
      u_ctx_trig_model.pulse();
      frm(1'b1);
    join
    act(1'b1, 1'b0);
    $display("test slave done");
  endtask
  task automatic t_rst2();
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(OFS_CTRL, 16'h0000, "ctrl_rst");
    rd(OFS_SET_A, 16'h0000, "set_a_rst");
    rd(OFS_CTX_MEM + 10'h0ff, 16'h0000, "mem_rst");
    chk("active_rst", 16'h0000, (|active_set_out) ? 16'h1 : 16'h0);
    $display("test second reset done");
  endtask
  initial begin
    {reset_n_in, wr_in, rd_in, internal_start_in} = 4'h0;
    {addr_in, wdata_in} = '0;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_regs();
    t_switch();
    t_slave();
    t_rst2();
    end_of_test();
  end
endmodule // tb
